// ---- core/mscfg_bank.sv ----
// Register bank for two sequencer step configuration words on APB.
// Assumes an APB master on pclk; the sequencer engine reads the outputs.
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps

// Behaviour
// RULE_01: Bit 15 includes the step in the multiplexed converter sequence.
// RULE_02: Bits 14:13 choose gain: 00 one, 01 two, 10 and 11 four.
// RULE_03: Bit 4 picks negative input: 0 analog ground, 1 external seven.
// RULE_04: Positive codes 0000 to 0111 select external inputs zero to seven.
// RULE_05: Positive codes 1000 and above route the internal sources.
// RULE_06: Internal sources choose the negative input and ignore bit 4.
// RULE_07: Reset clears enable, gain, negative; positive 1100; bits 12:5 zero.
// RULE_08: Next step register at index DD, reset value 000D.
// RULE_09: This step register at index DC, reset value 000C.
// RULE_10: Code 1011 is an internal source of unconfirmed kind, auto negative.
module mscfg_bank
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // This step, decoded
  output logic             step_include_bit,
  output logic [1:0]       step_gain_select,
  output logic [2:0]       step_ext_index,
  output logic [3:0]       step_positive_source,
  output logic [1:0]       step_negative_input_select,
  // Next step, decoded
  output logic             next_include_bit,
  output logic [1:0]       next_gain_select,
  output logic [2:0]       next_ext_index,
  output logic [3:0]       next_positive_source,
  output logic [1:0]       next_negative_input_select
);

  // ----------------------------------------------------------------------
  // Bus phase tracking
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MSCFG_IDLE   = 2'b00,
    MSCFG_ACCESS = 2'b01,
    MSCFG_DONE   = 2'b11
  } mscfg_state_t;

  mscfg_state_t state_q;
  mscfg_state_t state_d;

  logic [15:0] step_q;
  logic [15:0] step_d;
  logic [15:0] next_q;
  logic [15:0] next_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;

  logic        hit_step;
  logic        hit_next;
  logic        hit_any;
  logic        access;
  logic        commit;
  logic [15:0] lane_mask;

  logic             dec_s_inc;
  logic [1:0]       dec_s_gain;
  logic [2:0]       dec_s_idx;
  logic [3:0]       dec_s_src;
  logic [1:0]       dec_s_neg;
  logic             dec_n_inc;
  logic [1:0]       dec_n_gain;
  logic [2:0]       dec_n_idx;
  logic [3:0]       dec_n_src;
  logic [1:0]       dec_n_neg;

  // Registered copies of the decoded routing, one flop group per field
  logic             s_inc_q;
  logic             s_inc_d;
  logic [1:0]       s_gain_q;
  logic [1:0]       s_gain_d;
  logic [2:0]       s_idx_q;
  logic [2:0]       s_idx_d;
  logic [3:0]       s_src_q;
  logic [3:0]       s_src_d;
  logic [1:0]       s_neg_q;
  logic [1:0]       s_neg_d;
  logic             n_inc_q;
  logic             n_inc_d;
  logic [1:0]       n_gain_q;
  logic [1:0]       n_gain_d;
  logic [2:0]       n_idx_q;
  logic [2:0]       n_idx_d;
  logic [3:0]       n_src_q;
  logic [3:0]       n_src_d;
  logic [1:0]       n_neg_q;
  logic [1:0]       n_neg_d;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Upper address bits must be zero so aliases do not reach the bank
  always_comb
  begin
    hit_step = 1'b0;
    hit_next = 1'b0;
    if (paddr[31:mscfg_pkg::ADDR_W] != '0)
      hit_step = 1'b0;
    else if (paddr[mscfg_pkg::ADDR_W-1:0] == mscfg_pkg::STEP_CFG_ADDR)
      hit_step = 1'b1; // see RULE_09
    else if (paddr[mscfg_pkg::ADDR_W-1:0] == mscfg_pkg::STEP_NEXT_CFG_ADDR)
      hit_next = 1'b1; // see RULE_08
  end

  assign hit_any   = hit_step | hit_next;
  assign access    = psel & penable & (state_q == MSCFG_ACCESS);
  // Writes land at the edge where the master samples pready high
  assign commit    = psel & penable & (state_q == MSCFG_DONE);
  // Only the two low byte lanes carry register bits
  assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}} & mscfg_pkg::WR_MASK;

  // ----------------------------------------------------------------------
  // Transfer sequencing: one wait state, then a one-cycle pready
  // ----------------------------------------------------------------------
  // The wait state lets read data come from a flop without a comb path
  always_comb
  begin
    state_d   = state_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = prdata_q;
    case (state_q)
      MSCFG_IDLE:
      begin
        if (psel & ~penable)
          state_d = MSCFG_ACCESS;
      end
      MSCFG_ACCESS:
      begin
        if (access)
        begin
          state_d   = MSCFG_DONE;
          pready_d  = 1'b1;
          pslverr_d = ~hit_any;
          prdata_d  = mscfg_pkg::RDATA_ZERO;
          // Reserved bits are never stored, so they read back as zero
          if (~pwrite & hit_step)
            prdata_d = {16'h0000, step_q}; // see RULE_07
          else if (~pwrite & hit_next)
            prdata_d = {16'h0000, next_q};
        end
        else if (~psel)
          state_d = MSCFG_IDLE;
      end
      default:
      begin
        // Back-to-back setup may follow the completing edge at once
        if (psel & ~penable)
          state_d = MSCFG_ACCESS;
        else
          state_d = MSCFG_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Register writes, applied at the edge that carries pready
  // ----------------------------------------------------------------------
  always_comb
  begin
    step_d = step_q;
    next_d = next_q;
    if (commit & pwrite & hit_step)
      step_d = (step_q & ~lane_mask) | (pwdata[15:0] & lane_mask);
    if (commit & pwrite & hit_next)
      next_d = (next_q & ~lane_mask) | (pwdata[15:0] & lane_mask);
  end

  // Stored words; only constants in the reset branch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_q <= mscfg_pkg::STEP_CFG_RST;      // see RULE_07
      next_q <= mscfg_pkg::STEP_NEXT_CFG_RST; // see RULE_08
    end
    else
    begin
      step_q <= step_d;
      next_q <= next_d;
    end
  end

  // Bus answer and phase; every answer leaves from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q   <= MSCFG_IDLE;
      prdata_q  <= mscfg_pkg::RDATA_ZERO;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------------
  // Field decoding for both steps
  // ----------------------------------------------------------------------
  mscfg_decode u_dec_step
  (
    .cfg              (step_q),
    .step_include_bit (dec_s_inc),
    .gain_code        (dec_s_gain),
    .ext_pos_index    (dec_s_idx),
    .pos_source       (dec_s_src),
    .neg_route        (dec_s_neg)
  );

  mscfg_decode u_dec_next
  (
    .cfg              (next_q),
    .step_include_bit (dec_n_inc),
    .gain_code        (dec_n_gain),
    .ext_pos_index    (dec_n_idx),
    .pos_source       (dec_n_src),
    .neg_route        (dec_n_neg)
  );

  // Decoded routing is registered so the outputs leave from flops;
  // the cost is one cycle of lag behind the stored word
  always_comb
  begin
    s_inc_d  = dec_s_inc;  // see RULE_01
    s_gain_d = dec_s_gain; // see RULE_02
    s_idx_d  = dec_s_idx;  // see RULE_04
    s_src_d  = dec_s_src;  // see RULE_05
    s_neg_d  = dec_s_neg;  // see RULE_06
    n_inc_d  = dec_n_inc;
    n_gain_d = dec_n_gain;
    n_idx_d  = dec_n_idx;
    n_src_d  = dec_n_src;
    n_neg_d  = dec_n_neg;
  end

  // Zero during reset; the stored image shows one edge after release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_inc_q  <= '0;
      s_gain_q <= '0;
      s_idx_q  <= '0;
      s_src_q  <= '0;
      s_neg_q  <= '0;
      n_inc_q  <= '0;
      n_gain_q <= '0;
      n_idx_q  <= '0;
      n_src_q  <= '0;
      n_neg_q  <= '0;
    end
    else
    begin
      s_inc_q  <= s_inc_d;
      s_gain_q <= s_gain_d;
      s_idx_q  <= s_idx_d;
      s_src_q  <= s_src_d;
      s_neg_q  <= s_neg_d;
      n_inc_q  <= n_inc_d;
      n_gain_q <= n_gain_d;
      n_idx_q  <= n_idx_d;
      n_src_q  <= n_src_d;
      n_neg_q  <= n_neg_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Each output is one flop group, so no field can shift into another
  assign prdata                     = prdata_q;
  assign pready                     = pready_q;
  assign pslverr                    = pslverr_q;
  assign step_include_bit           = s_inc_q;
  assign step_gain_select           = s_gain_q;
  assign step_ext_index             = s_idx_q;
  assign step_positive_source       = s_src_q;
  assign step_negative_input_select = s_neg_q;
  assign next_include_bit           = n_inc_q;
  assign next_gain_select           = n_gain_q;
  assign next_ext_index             = n_idx_q;
  assign next_positive_source       = n_src_q;
  assign next_negative_input_select = n_neg_q;

endmodule

// ---- core/mscfg_decode.sv ----
// Decoder that turns one step image into converter routing controls.
// Assumes a stored register image from the bank; purely combinational.
`timescale 1ns/100ps

module mscfg_decode
(
  // Stored step image
  input  wire logic [15:0] cfg,
  // Decoded controls
  output logic             step_include_bit,
  output logic [1:0]       gain_code,
  output logic [2:0]       ext_pos_index,
  output logic [3:0]       pos_source,
  output logic [1:0]       neg_route
);

  logic [3:0] pos_sel;
  logic       neg_sel;
  logic [1:0] gsel;

  // Field extraction
  assign pos_sel = cfg[mscfg_pkg::POS_HI:mscfg_pkg::POS_LO];
  assign neg_sel = cfg[mscfg_pkg::NEG_BIT];
  assign gsel    = cfg[mscfg_pkg::GAIN_HI:mscfg_pkg::GAIN_LO];

  // Step membership of the sequence
  assign step_include_bit = cfg[mscfg_pkg::EN_BIT]; // see RULE_01

  // Gain: both upper codes collapse to gain 4
  always_comb
  begin
    case (gsel)
      2'h0:    gain_code = mscfg_pkg::MSCFG_GAIN_1; // see RULE_02
      2'h1:    gain_code = mscfg_pkg::MSCFG_GAIN_2; // see RULE_02
      default: gain_code = mscfg_pkg::MSCFG_GAIN_4; // see RULE_02
    endcase
  end

  // Positive routing; external inputs carry their index in the low bits
  always_comb
  begin
    ext_pos_index = pos_sel[2:0]; // see RULE_04
    case (pos_sel)
      mscfg_pkg::POS_TEMP:    pos_source = mscfg_pkg::MSCFG_SRC_TEMP;
      mscfg_pkg::POS_SHORT:   pos_source = mscfg_pkg::MSCFG_SRC_SHORT;
      mscfg_pkg::POS_DAC:     pos_source = mscfg_pkg::MSCFG_SRC_DAC;
      // Source of this code is unconfirmed; routed as internal
      mscfg_pkg::POS_UNCONF:  pos_source = mscfg_pkg::MSCFG_SRC_UNCONF; // see RULE_10
      mscfg_pkg::POS_IO_DIV:  pos_source = mscfg_pkg::MSCFG_SRC_IO_DIV; // see RULE_05
      mscfg_pkg::POS_DIG_DIV: pos_source = mscfg_pkg::MSCFG_SRC_DIG_DIV;
      mscfg_pkg::POS_ANALOG_POWER_INPUT:    pos_source = mscfg_pkg::MSCFG_SRC_ANALOG_POWER_INPUT;
      mscfg_pkg::POS_DIGITAL_POWER_INPUT:    pos_source = mscfg_pkg::MSCFG_SRC_DIGITAL_POWER_INPUT;
      default:                pos_source = mscfg_pkg::MSCFG_SRC_EXT;
    endcase
  end

  // Internal sources pick the negative input themselves, ignoring bit 4
  always_comb
  begin
    if (pos_sel >= mscfg_pkg::NEG_AUTO_MIN)
      neg_route = mscfg_pkg::NEG_AUTO; // see RULE_06
    else if (neg_sel)
      neg_route = mscfg_pkg::NEG_EXT7; // see RULE_03
    else
      neg_route = mscfg_pkg::NEG_AGND; // see RULE_03
  end

endmodule

// ---- core/mscfg_pkg.sv ----
// Package for the multiplexed converter step configuration register bank.
// Assumes a 16-bit register image carried in the low half of a 32-bit bus.
package mscfg_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  // Printed offsets are word indices; the byte address is four times that
  localparam logic [7:0]  STEP_CFG_IDX      = 8'hDC;
  localparam logic [7:0]  STEP_NEXT_CFG_IDX = 8'hDD;
  localparam logic [9:0]  STEP_CFG_ADDR      = {STEP_CFG_IDX, 2'b00};
  localparam logic [9:0]  STEP_NEXT_CFG_ADDR = {STEP_NEXT_CFG_IDX, 2'b00};
  localparam int          ADDR_W            = 10;
  localparam int          REG_W             = 16;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int          EN_BIT   = 15;
  localparam int          GAIN_HI  = 14;
  localparam int          GAIN_LO  = 13;
  localparam int          NEG_BIT  = 4;
  localparam int          POS_HI   = 3;
  localparam int          POS_LO   = 0;
  localparam logic [15:0] WR_MASK  = 16'hE01F;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] STEP_CFG_RST      = 16'h000C;
  localparam logic [15:0] STEP_NEXT_CFG_RST = 16'h000D;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MSCFG_GAIN_1 = 2'h0,
    MSCFG_GAIN_2 = 2'h1,
    MSCFG_GAIN_4 = 2'h2
  } mscfg_gain_t;

  // Positive routing classes decoded from the 4-bit selection
  typedef enum logic [3:0] {
    MSCFG_SRC_EXT     = 4'h0,
    MSCFG_SRC_TEMP    = 4'h1,
    MSCFG_SRC_SHORT   = 4'h2,
    MSCFG_SRC_DAC     = 4'h3,
    MSCFG_SRC_UNCONF  = 4'h4,
    MSCFG_SRC_IO_DIV  = 4'h5,
    MSCFG_SRC_DIG_DIV = 4'h6,
    MSCFG_SRC_ANALOG_POWER_INPUT    = 4'h7,
    MSCFG_SRC_DIGITAL_POWER_INPUT    = 4'h8
  } mscfg_src_t;

  localparam logic [3:0] POS_TEMP     = 4'h8;
  localparam logic [3:0] POS_SHORT    = 4'h9;
  localparam logic [3:0] POS_DAC      = 4'hA;
  localparam logic [3:0] POS_UNCONF   = 4'hB;
  localparam logic [3:0] POS_IO_DIV   = 4'hC;
  localparam logic [3:0] POS_DIG_DIV  = 4'hD;
  localparam logic [3:0] POS_ANALOG_POWER_INPUT     = 4'hE;
  localparam logic [3:0] POS_DIGITAL_POWER_INPUT     = 4'hF;
  localparam logic [3:0] NEG_AUTO_MIN = 4'h8;

  // Negative input selection values
  localparam logic [1:0] NEG_AGND = 2'h0;
  localparam logic [1:0] NEG_EXT7 = 2'h1;
  localparam logic [1:0] NEG_AUTO = 2'h2;

  // APB answer values
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage

// ---- sim/mscfg_bank_monitor.sv ----
// Concurrent checks on the APB answer and decoded routing of the bank.
// Assumes it is bound onto mscfg_bank; one pclk domain, presetn low reset.
`timescale 1ns/100ps

module mscfg_bank_monitor
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Decoded routing
  input wire logic [1:0]  step_gain_select,
  input wire logic [3:0]  step_positive_source,
  input wire logic [1:0]  step_negative_input_select,
  input wire logic [3:0]  next_positive_source,
  input wire logic [1:0]  next_negative_input_select
);
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Only the two word addresses answer cleanly; master holds paddr
  logic mapped;
  assign mapped = (paddr == 32'h0000_0370) || (paddr == 32'h0000_0374);

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_ready_bound: assert property (psel && !penable |-> ##[1:3] pready)
    else $error("no pready within three cycles of setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address decode");
  a_rsvd_zero: assert property (pready && !pwrite |->
    prdata[31:16] == 16'h0000 && prdata[12:5] == 8'h00)
    else $error("reserved read bits not zero");
  a_gain_legal: assert property (step_gain_select != 2'h3)
    else $error("gain select outside three gains");
  a_step_auto: assert property (step_positive_source != 4'h0 |->
    step_negative_input_select == 2'h2)
    else $error("internal source without automatic negative");
  a_step_manual: assert property (step_positive_source == 4'h0 |->
    step_negative_input_select != 2'h2)
    else $error("external source with automatic negative");
  a_next_auto: assert property (next_positive_source != 4'h0 |->
    next_negative_input_select == 2'h2)
    else $error("next step internal source without automatic negative");

  // Main scenarios reached
  c_write: cover property (pready && pwrite);
  c_error: cover property (pready && pslverr);
  c_unconf: cover property (step_positive_source == 4'h4);
endmodule

bind mscfg_bank mscfg_bank_monitor mscfg_bank_monitor_inst
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .step_gain_select, .step_positive_source,
  .step_negative_input_select, .next_positive_source,
  .next_negative_input_select
);

// ---- sim/mux_adc_seq_step_config_bench.sv ----
// Self-checking bench for the two step configuration registers.
// Assumes the package, the bank and its bound monitor compile first.
`timescale 1ns/100ps

module mux_adc_seq_step_config_bench;

  // --------------------------------------------------------------------
  // Signals and model state
  // --------------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd, d;
  logic [3:0]  pstrb, s;
  wire  [1:0][11:0] dec;
  logic [15:0] model_q [2];
  int          bad_count, num_checks, seed, r;

  mscfg_bank mscfg_bank_inst
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr,
    .step_include_bit           (dec[0][11]),
    .step_gain_select           (dec[0][10:9]),
    .step_ext_index             (dec[0][8:6]),
    .step_positive_source       (dec[0][5:2]),
    .step_negative_input_select (dec[0][1:0]),
    .next_include_bit           (dec[1][11]),
    .next_gain_select           (dec[1][10:9]),
    .next_ext_index             (dec[1][8:6]),
    .next_positive_source       (dec[1][5:2]),
    .next_negative_input_select (dec[1][1:0])
  );

  // Clock and watchdog; the whole run needs well under 2000 cycles
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial
  begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    tally_and_finish();
  end

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One APB transfer; ends one edge after release so calls never collide
  task automatic apb(logic wr, logic [31:0] a, logic [31:0] wd,
                     logic [3:0] st);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Expected routing of one stored word, worked out from the field layout
  function automatic logic [11:0] exp_dec(logic [15:0] v);
    logic [1:0] g;
    g = (v[14:13] == 2'h0) ? 2'h0 : (v[14:13] == 2'h1) ? 2'h1 : 2'h2;
    return {v[15], g, v[2:0], v[3] ? v[3:0] - 4'h7 : 4'h0,
            v[3] ? 2'h2 : {1'b0, v[4]}};
  endfunction

  // Read both words back and compare routing; decode lags by a cycle
  task automatic check_all();
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b0, 32'h0000_0370 + k * 4, 32'h0000_0000, 4'h0);
      check("readback", rd, {16'h0000, model_q[k]});
      check("read error", err, 1'b0);
      check("routing", dec[k], exp_dec(model_q[k]));
    end
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    seed = 66;
    model_q[0] = 16'h000C;
    model_q[1] = 16'h000D;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check_all();
    $display("test reset done");
    // Every positive code with both negative bits, on each word; every
    // eighth write strobes the low lane only
    for (int i = 0; i < 64; i++)
    begin
      r = i / 32;
      d = $random(seed);
      d[4:0] = i[4:0];
      s = (i % 8 == 7) ? 4'h1 : 4'hF;
      apb(1'b1, 32'h0000_0370 + r * 4, d, s);
      check("write error", err, 1'b0);
      if (s[1])
        model_q[r][15:8] = d[15:8];
      model_q[r][7:0] = d[7:0];
      model_q[r] = model_q[r] & 16'hE01F;
      check_all();
    end
    $display("test fields done");
    // Unmapped word and upper lanes only: both refused or ignored
    d = $random(seed);
    apb(1'b1, 32'h0000_0378, d, 4'hF);
    check("unmapped write", err, 1'b1);
    apb(1'b0, 32'h0000_0378, 32'h0000_0000, 4'h0);
    check("unmapped data", rd, 32'h0000_0000);
    apb(1'b1, 32'h0000_0370, d, 4'hC);
    check_all();
    $display("test refusal done");
    tally_and_finish();
  end
endmodule
